/* rtl/sld_defs.vh */
// sld_defs.vh: register offsets, field positions, reset values and codes
// of the segment lcd driver control block; definitions only.
`ifndef SLD_DEFS_VH
`define SLD_DEFS_VH
`define SLD_OFS_CLOCK 8'h00
`define SLD_OFS_CONTROL 8'h04
`define SLD_OFS_TIMING1 8'h08
`define SLD_OFS_TIMING2 8'h0c
`define SLD_OFS_POWER 8'h10
`define SLD_OFS_DISPLAY 8'h14
`define SLD_OFS_IRQ_FLAG 8'h18
`define SLD_OFS_IRQ_ENABLE 8'h1c
`define SLD_OFS_STATUS 8'h20
// power register fields
`define SLD_PWR_EXT 0
`define SLD_PWR_REG 1
`define SLD_PWR_BST 2
`define SLD_PWR_BIAS 3
`define SLD_PWR_REF 4
`define SLD_PWR_HEAVY_LOAD_PROTECT 5
`define SLD_PWR_LC_LO 8
`define SLD_PWR_LC_HI 12
// control register fields
`define SLD_CTL_MOD 0
`define SLD_CTL_DIS 1
// timing1 fields
`define SLD_TIM1_DUTY_LO 0
`define SLD_TIM1_DUTY_HI 2
`define SLD_TIM1_FRM_LO 8
`define SLD_TIM1_FRM_HI 11
// timing2 fields
`define SLD_TIM2_NL_LO 0
`define SLD_TIM2_NL_HI 2
`define SLD_TIM2_BC_LO 8
`define SLD_TIM2_BC_HI 9
// display fields
`define SLD_DSP_ST_LO 0
`define SLD_DSP_ST_HI 1
`define SLD_DSP_INVN 4
`define SLD_DSP_AREA 8
`define SLD_DSP_COMO 9
`define SLD_DSP_SEGO 10
// clock fields
`define SLD_CLK_SRC_LO 0
`define SLD_CLK_SRC_HI 1
`define SLD_CLK_DIV_LO 4
`define SLD_CLK_DIV_HI 6
// display states
`define SLD_ST_OFF 2'h0
`define SLD_ST_NORMAL 2'h1
`define SLD_ST_ALLON 2'h2
`define SLD_ST_ALLOFF 2'h3
// reset values
`define SLD_RST_POWER 13'h0000
`define SLD_RST_DISPLAY 11'h010
// cycles of mclk per lcd clock tick (about 32 kHz from 250 MHz)
`define SLD_LCD_TICK_DIV 13'h1e85
`endif

/* rtl/sld_lcd_ctrl.v */
// sld_lcd_ctrl.v: power, display state and pin-role control of a segment lcd
// driver, with an AHB-Lite register slave. Assumes one single-word master,
// a panel-side analog block taking the decoded controls, and a frame counter.
// Operation
// RULE1: ext select 0, regulator and booster on: generate all four voltages internally.
// RULE2: ext select 1, both off: regulator and booster off, all voltages external.
// RULE3: ext select 1, regulator off, booster on: one external voltage, rest boosted.
// RULE4: bias select 0 gives 1/3 bias, 1 gives 1/4 bias.
// RULE5: reference select picks first or second drive voltage as boost reference.
// RULE6: heavy-load bit 1 puts the regulator into heavy load protection.
// RULE7: two-bit booster clock field picks one of four booster clocks.
// RULE8: five-bit contrast field sets one of 32 regulator levels.
// RULE9: contrast has no effect in either external voltage mode.
// RULE10: software initializes ports, clock, control, timing, power, display, RAM, interrupt.
// RULE11: writing 1 clears frame flag; enable bit 1 enables the interrupt.
// RULE12: module enable bit 1 enables the block's operating clock.
// RULE13: discharge enable bit 1 lets pins discharge when display is off.
// RULE14: two-bit state field: all off static, all on, normal, display off.
// RULE15: display off with discharge: stop drive supply, all pins to ground.
// RULE16: all on/off override waveform, RAM untouched; commons dynamic or static.
// RULE17: software removes external supply, toggles ext select 0 then 1 before off.
// RULE18: inversion bit 0 inverts the image, 1 shows it normally.
// RULE19: inversion has no effect in the all-off state.
// RULE20: three-bit duty: 0x7 is 1/8 down to 0x0 static, commons 0..code active.
// RULE21: shared pins are commons 4-7 for 1/5 and above, segments 0-3 otherwise.
// RULE22: unused commons output an off waveform.
// RULE23: frame count field holds 0 to 15, duty field 0 to 7.
// RULE24: state codes 0x2 all on, 0x1 normal, 0x0 display off.
// RULE25: frame flag set once per frame, stays until software clears it.
//
// The AHB-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "sld_defs.vh"
module sld_lcd_ctrl (
  input wire mclk,
  input wire resetn,
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  input wire frameTick,
  output reg lcdClkEn,
  output reg lcdTick,
  output reg regulatorOn,
  output reg boosterOn,
  output reg [3:0] extVoltageMask,
  output reg biasQuarter,
  output reg boostRefSecond,
  output reg heavyLoadOn,
  output reg [1:0] boosterClkSel,
  output reg [4:0] contrastOut,
  output reg contrastActive,
  output reg driveSupplyOn,
  output reg pinsGrounded,
  output reg waveAllOn,
  output reg waveAllOff,
  output reg commonStatic,
  output reg waveInvert,
  output reg [2:0] dutyOut,
  output reg [7:0] comActive,
  output reg [3:0] sharedIsSeg,
  output reg [3:0] frameDivOut,
  output reg [2:0] invLineOut,
  output reg areaSel,
  output reg comOrder,
  output reg segOrder,
  output reg [1:0] clkSrcOut,
  output reg [2:0] clkDivOut,
  output reg frameIrq
);
  localparam [1:0] HTRANS_NONSEQ = 2'h2;
  reg [1:0] clkSel_r;
  reg [2:0] clkDiv_r;
  reg moduleEn_r;
  reg dischargeEn_r;
  reg [2:0] duty_r;
  reg [3:0] frameDiv_r;
  reg [2:0] invLine_r;
  reg [1:0] bstClk_r;
  reg [12:0] power_r;
  reg [10:0] display_r;
  reg frameFlag_r;
  reg frameIe_r;
  reg wrPend_r;
  reg [7:0] wrAddr_r;
  reg [12:0] tickCnt_r;
  reg [12:0] tickCnt_nxt;
  reg frameFlag_nxt;
  reg [31:0] readWord;
  wire [1:0] state;
  wire extSel;
  wire regEn;
  wire booster_enable;
  wire internalMode;
  wire ext1Mode;
  wire ext2Mode;
  wire addrPhase;
  wire wrHit;
  wire readReq;
  wire tickWrap;
  wire flagClear;
  wire groundReq;
  integer i;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addrPhase = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign wrHit = wrPend_r;
  // hsize is not checked: every register is one aligned word
  assign readReq = addrPhase && !hwrite;
  assign state = display_r[`SLD_DSP_ST_HI:`SLD_DSP_ST_LO]; // RULE14
  assign extSel = power_r[`SLD_PWR_EXT];
  assign regEn = power_r[`SLD_PWR_REG];
  assign booster_enable = power_r[`SLD_PWR_BST];
  assign internalMode = !extSel && regEn && booster_enable; // RULE1
  assign ext1Mode = extSel && !regEn && !booster_enable; // RULE2
  assign ext2Mode = extSel && !regEn && booster_enable; // RULE3
  assign tickWrap = (tickCnt_r == `SLD_LCD_TICK_DIV - 13'h0001);
  assign flagClear = wrHit && (wrAddr_r == `SLD_OFS_IRQ_FLAG) && hwdata[0]; // RULE11
  // display off with discharge grounds every pin, so the drive supply must drop too
  assign groundReq = (state == `SLD_ST_OFF) && dischargeEn_r; // RULE15

  // write data arrives one cycle after the address phase
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      wrPend_r <= 1'b0;
      wrAddr_r <= 8'h00;
    end
    else
    begin
      wrPend_r <= addrPhase && hwrite;
      wrAddr_r <= haddr;
    end
  end

  always @*
  begin
    frameFlag_nxt = frameFlag_r;
    if (flagClear)
    begin
      frameFlag_nxt = 1'b0; // RULE11
    end
    // a frame in the clearing cycle wins over the clear
    if (frameTick && moduleEn_r)
    begin
      frameFlag_nxt = 1'b1; // RULE25
    end
  end

  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      clkSel_r <= 2'h0;
      clkDiv_r <= 3'h0;
      moduleEn_r <= 1'b0;
      dischargeEn_r <= 1'b0;
      duty_r <= 3'h0;
      frameDiv_r <= 4'h0;
      invLine_r <= 3'h0;
      bstClk_r <= 2'h0;
      power_r <= `SLD_RST_POWER;
      display_r <= `SLD_RST_DISPLAY;
      frameFlag_r <= 1'b0;
      frameIe_r <= 1'b0;
    end
    else
    begin
      frameFlag_r <= frameFlag_nxt;
      if (wrHit)
      begin
        if (wrAddr_r == `SLD_OFS_CLOCK)
        begin
          clkSel_r <= hwdata[`SLD_CLK_SRC_HI:`SLD_CLK_SRC_LO];
          clkDiv_r <= hwdata[`SLD_CLK_DIV_HI:`SLD_CLK_DIV_LO];
        end
        else if (wrAddr_r == `SLD_OFS_CONTROL)
        begin
          moduleEn_r <= hwdata[`SLD_CTL_MOD]; // RULE12
          dischargeEn_r <= hwdata[`SLD_CTL_DIS]; // RULE13
        end
        else if (wrAddr_r == `SLD_OFS_TIMING1)
        begin
          duty_r <= hwdata[`SLD_TIM1_DUTY_HI:`SLD_TIM1_DUTY_LO]; // RULE23
          frameDiv_r <= hwdata[`SLD_TIM1_FRM_HI:`SLD_TIM1_FRM_LO]; // RULE23
        end
        else if (wrAddr_r == `SLD_OFS_TIMING2)
        begin
          invLine_r <= hwdata[`SLD_TIM2_NL_HI:`SLD_TIM2_NL_LO];
          bstClk_r <= hwdata[`SLD_TIM2_BC_HI:`SLD_TIM2_BC_LO]; // RULE7
        end
        else if (wrAddr_r == `SLD_OFS_POWER)
        begin
          power_r <= {hwdata[12:8], 2'h0, hwdata[5:0]};
        end
        else if (wrAddr_r == `SLD_OFS_DISPLAY)
        begin
          display_r <= {hwdata[10:8], 3'h0, hwdata[4], 2'h0, hwdata[1:0]};
        end
        else if (wrAddr_r == `SLD_OFS_IRQ_ENABLE)
        begin
          frameIe_r <= hwdata[0]; // RULE11
        end
      end
    end
  end

  // read word decoded during the address phase; unmapped offsets read as zero
  always @*
  begin
    readWord = 32'h00000000;
    if (haddr == `SLD_OFS_CLOCK)
    begin
      readWord = {25'h0, clkDiv_r, 2'h0, clkSel_r};
    end
    else if (haddr == `SLD_OFS_CONTROL)
    begin
      readWord = {30'h0, dischargeEn_r, moduleEn_r};
    end
    else if (haddr == `SLD_OFS_TIMING1)
    begin
      readWord = {20'h0, frameDiv_r, 5'h0, duty_r};
    end
    else if (haddr == `SLD_OFS_TIMING2)
    begin
      readWord = {22'h0, bstClk_r, 5'h0, invLine_r};
    end
    else if (haddr == `SLD_OFS_POWER)
    begin
      readWord = {19'h0, power_r};
    end
    else if (haddr == `SLD_OFS_DISPLAY)
    begin
      readWord = {21'h0, display_r};
    end
    else if (haddr == `SLD_OFS_IRQ_FLAG)
    begin
      readWord = {31'h0, frameFlag_r};
    end
    else if (haddr == `SLD_OFS_IRQ_ENABLE)
    begin
      readWord = {31'h0, frameIe_r};
    end
    else if (haddr == `SLD_OFS_STATUS)
    begin
      readWord = {26'h0, pinsGrounded, driveSupplyOn, contrastActive, ext2Mode, ext1Mode, internalMode};
    end
  end

  // registered so hrdata is a flop output and stands for the whole data phase
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      hrdata <= 32'h00000000;
    end
    else if (readReq)
    begin
      hrdata <= readWord;
    end
  end

  // lcd clock tick: divider from mclk, gated by the module enable
  // the counter idles at zero while disabled, so the first tick lands a full period after enable
  always @*
  begin
    tickCnt_nxt = tickCnt_r + 13'h0001;
    if (!moduleEn_r || tickWrap)
    begin
      tickCnt_nxt = 13'h0000;
    end
  end

  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      tickCnt_r <= 13'h0000;
      lcdTick <= 1'b0;
    end
    else
    begin
      tickCnt_r <= tickCnt_nxt;
      lcdTick <= moduleEn_r && tickWrap; // RULE12
    end
  end

  // decoded analog and waveform controls, all registered
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      lcdClkEn <= 1'b0;
      regulatorOn <= 1'b0;
      boosterOn <= 1'b0;
      extVoltageMask <= 4'h0;
      biasQuarter <= 1'b0;
      boostRefSecond <= 1'b0;
      heavyLoadOn <= 1'b0;
      boosterClkSel <= 2'h0;
      contrastOut <= 5'h00;
      contrastActive <= 1'b0;
      driveSupplyOn <= 1'b0;
      pinsGrounded <= 1'b0;
      waveAllOn <= 1'b0;
      waveAllOff <= 1'b0;
      commonStatic <= 1'b0;
      waveInvert <= 1'b0;
      dutyOut <= 3'h0;
      comActive <= 8'h00;
      sharedIsSeg <= 4'h0;
      frameDivOut <= 4'h0;
      invLineOut <= 3'h0;
      areaSel <= 1'b0;
      comOrder <= 1'b0;
      segOrder <= 1'b0;
      clkSrcOut <= 2'h0;
      clkDivOut <= 3'h0;
      frameIrq <= 1'b0;
    end
    else
    begin
      lcdClkEn <= moduleEn_r; // RULE12
      regulatorOn <= internalMode; // RULE1
      boosterOn <= internalMode || ext2Mode; // RULE3
      // mixed enable codes fall back to no generator and no external rail
      if (ext1Mode)
      begin
        extVoltageMask <= 4'hf; // RULE2
      end
      else if (ext2Mode)
      begin
        extVoltageMask <= 4'h1; // RULE3
      end
      else
      begin
        extVoltageMask <= 4'h0;
      end
      biasQuarter <= power_r[`SLD_PWR_BIAS]; // RULE4
      boostRefSecond <= power_r[`SLD_PWR_REF]; // RULE5
      heavyLoadOn <= internalMode && power_r[`SLD_PWR_HEAVY_LOAD_PROTECT]; // RULE6
      boosterClkSel <= bstClk_r; // RULE7
      contrastOut <= power_r[`SLD_PWR_LC_HI:`SLD_PWR_LC_LO]; // RULE8
      contrastActive <= internalMode; // RULE9
      driveSupplyOn <= moduleEn_r && !groundReq; // RULE15
      pinsGrounded <= groundReq; // RULE15
      waveAllOn <= (state == `SLD_ST_ALLON); // RULE16 RULE14 RULE24
      waveAllOff <= (state == `SLD_ST_ALLOFF); // RULE16
      commonStatic <= (state == `SLD_ST_ALLOFF); // RULE16
      waveInvert <= !display_r[`SLD_DSP_INVN] && (state != `SLD_ST_ALLOFF); // RULE18 RULE19
      dutyOut <= duty_r;
      // commons beyond the duty stay inactive so their segments see an off waveform
      for (i = 0; i < 8; i = i + 1)
      begin
        comActive[i] <= (i <= duty_r); // RULE20 RULE22
      end
      sharedIsSeg <= (duty_r <= 3'h3) ? 4'hf : 4'h0; // RULE21
      frameDivOut <= frameDiv_r;
      invLineOut <= invLine_r;
      areaSel <= display_r[`SLD_DSP_AREA];
      comOrder <= display_r[`SLD_DSP_COMO];
      segOrder <= display_r[`SLD_DSP_SEGO];
      clkSrcOut <= clkSel_r;
      clkDivOut <= clkDiv_r;
      frameIrq <= frameFlag_r && frameIe_r; // RULE11
    end
  end
endmodule

/* test/sld_lcd_ctrl_props.sv */
// sld_lcd_ctrl_props.sv: concurrent checks on the lcd control outputs.
// assumes a bind onto sld_lcd_ctrl and the single mclk domain.
`timescale 1ns/1ps
module sld_lcd_ctrl_props (
  input wire mclk,
  input wire resetn,
  input wire lcdClkEn,
  input wire lcdTick,
  input wire regulatorOn,
  input wire boosterOn,
  input wire [3:0] extVoltageMask,
  input wire contrastActive,
  input wire pinsGrounded,
  input wire waveAllOn,
  input wire waveAllOff,
  input wire commonStatic,
  input wire waveInvert,
  input wire [2:0] dutyOut,
  input wire [7:0] comActive,
  input wire [3:0] sharedIsSeg
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  sequence tickSeen;
    lcdTick && lcdClkEn;
  endsequence
  sequence quietRun;
    (!lcdTick) [*8];
  endsequence
  int_gen_a: assert property (regulatorOn |-> boosterOn && extVoltageMask == 4'h0)
    else $error("internal mode not fully internal");
  ext_all_a: assert property (extVoltageMask == 4'hf |-> !regulatorOn && !boosterOn)
    else $error("external mode 1 left a generator on");
  ext_one_a: assert property (extVoltageMask == 4'h1 |-> boosterOn && !regulatorOn)
    else $error("external mode 2 generator mix wrong");
  contrast_gate_a: assert property (contrastActive == regulatorOn)
    else $error("contrast active outside internal mode");
  ground_state_a: assert property (pinsGrounded |-> !waveAllOn && !waveAllOff)
    else $error("pins grounded outside display off");
  all_off_a: assert property (waveAllOff == commonStatic && !(waveAllOff && waveAllOn))
    else $error("all off without static commons");
  no_invert_a: assert property (waveAllOff |-> !waveInvert)
    else $error("inversion in all off state");
  duty_com_a: assert property (|comActive |-> comActive == (8'hff >> (3'h7 - dutyOut)))
    else $error("active commons do not follow duty");
  shared_pin_a: assert property (|comActive |-> sharedIsSeg == ((dutyOut < 3'h4) ? 4'hf : 4'h0))
    else $error("shared pin role wrong for duty");
  tick_pulse_a: assert property (tickSeen |=> quietRun)
    else $error("operating clock tick too frequent");
endmodule

/* test/sld_panel_model.sv */
// sld_panel_model.sv: panel side and frame source for the lcd control bench.
// assumes frameTick sampled on mclk; supply switch driven by the bench.
`timescale 1ns/1ps
module sld_panel_model (
  input wire mclk,
  input wire lcdClkEn,
  input wire extSupplyOn,
  output reg frameTick = 1'b0,
  output reg supplyLive = 1'b0
);
  reg [5:0] cnt_r = 6'h00;
  // short frames keep the run brief; no frames while the clock is stopped
  always @(posedge mclk)
  begin
    cnt_r <= lcdClkEn ? cnt_r + 6'h01 : 6'h00;
    frameTick <= lcdClkEn && (cnt_r == 6'h3f);
    supplyLive <= extSupplyOn;
  end
endmodule

/* test/sld_lcd_ctrl_test.sv */
// sld_lcd_ctrl_test.sv: self-checking bench for sld_lcd_ctrl.
// assumes a zero-wait AHB-Lite slave and the panel model as frame source.
`timescale 1ns/1ps
`include "sld_defs.vh"
module sld_lcd_ctrl_test;
  reg mclk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, extSupply = 1'b1;
  reg [7:0] haddr = 8'h00;
  reg [1:0] htrans = 2'h0;
  reg [2:0] hsize = 3'h2;
  reg [31:0] hwdata = 32'h0, rd;
  wire [31:0] hrdata;
  wire hreadyout, hresp, frameTick, supplyLive, lcdClkEn, lcdTick, regulatorOn, boosterOn, biasQuarter;
  wire boostRefSecond, heavyLoadOn, contrastActive, pinsGrounded, waveAllOn, waveAllOff, commonStatic;
  wire waveInvert, frameIrq, driveSupplyOn, areaSel, comOrder, segOrder;
  wire [3:0] extVoltageMask, sharedIsSeg, frameDivOut;
  wire [1:0] boosterClkSel, clkSrcOut;
  wire [4:0] contrastOut;
  wire [2:0] dutyOut, invLineOut, clkDivOut;
  wire [7:0] comActive;
  integer miscompares = 0, tests_run = 0, cyc = 0, i, s, v, d, r;
  always #2 mclk = ~mclk;
  sld_lcd_ctrl sld_lcd_ctrl_i (.mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .frameTick(frameTick), .lcdClkEn(lcdClkEn), .lcdTick(lcdTick),
    .regulatorOn(regulatorOn), .boosterOn(boosterOn), .extVoltageMask(extVoltageMask),
    .biasQuarter(biasQuarter), .boostRefSecond(boostRefSecond), .heavyLoadOn(heavyLoadOn),
    .boosterClkSel(boosterClkSel), .contrastOut(contrastOut), .contrastActive(contrastActive),
    .driveSupplyOn(driveSupplyOn), .pinsGrounded(pinsGrounded), .waveAllOn(waveAllOn), .waveAllOff(waveAllOff),
    .commonStatic(commonStatic), .waveInvert(waveInvert), .dutyOut(dutyOut), .comActive(comActive),
    .sharedIsSeg(sharedIsSeg), .frameDivOut(frameDivOut), .invLineOut(invLineOut), .areaSel(areaSel),
    .comOrder(comOrder), .segOrder(segOrder), .clkSrcOut(clkSrcOut), .clkDivOut(clkDivOut), .frameIrq(frameIrq));
  sld_panel_model sld_panel_model_i (.mclk(mclk), .lcdClkEn(lcdClkEn), .extSupplyOn(extSupply),
    .frameTick(frameTick), .supplyLive(supplyLive));
  task chk(input [8*8:1] nm, input [31:0] seen, input [31:0] exp);
  begin
    tests_run = tests_run + 1;
    if (seen !== exp)
    begin
      miscompares = miscompares + 1;
      $display("ERROR %0s exp %h seen %h", nm, exp, seen);
    end
  end
  endtask
  // one transfer, then two edges so written outputs have landed
  task bus(input w, input [7:0] a, input [31:0] dat);
  begin
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= dat;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rd = hrdata;
    repeat (2) @(posedge mclk);
  end
  endtask
  task close_out;
  begin
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask
  always @(posedge mclk)
  begin
    cyc = cyc + 1;
    if (cyc == 40000)
    begin
      miscompares = miscompares + 1;
      close_out;
    end
  end
  initial
  begin
    r = $urandom(10906);
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    bus(0, `SLD_OFS_DISPLAY, 0);
    chk("disprst", rd, `SLD_RST_DISPLAY);
    chk("okay", {hreadyout, hresp}, 2);
    bus(0, 8'h3c, 0);
    chk("unmapped", rd, 0);
    v = $urandom;
    bus(1, `SLD_OFS_CLOCK, v);
    chk("clksrc", clkSrcOut, v & 3);
    chk("clkdiv", clkDivOut, v >> 4 & 7);
    bus(1, `SLD_OFS_CONTROL, 3);
    chk("clken", lcdClkEn, 1);
    for (i = 0; i < 8; i = i + 1)
    begin
      v = ($urandom & 15) << 8 | i;
      bus(1, `SLD_OFS_TIMING1, v);
      bus(1, `SLD_OFS_TIMING2, i | (i & 3) << 8);
      chk("duty", dutyOut, i);
      chk("coms", comActive, (2 << i) - 1);
      chk("shared", sharedIsSeg, i < 4 ? 15 : 0);
      chk("frmdiv", frameDivOut, v >> 8);
      chk("invline", invLineOut, i);
      chk("bstclk", boosterClkSel, i & 3);
    end
    $display("end timing");
    for (i = 0; i < 4; i = i + 1)
    begin
      r = $urandom;
      bus(1, `SLD_OFS_POWER, r & 32'h1f38 | (i == 0 ? 6 : i == 1 ? 1 : i == 2 ? 5 : 4));
      chk("reg", regulatorOn, i == 0);
      chk("bst", boosterOn, i == 0 || i == 2);
      chk("extmask", extVoltageMask, i == 1 ? 15 : i == 2);
      chk("bias", biasQuarter, r >> 3 & 1);
      chk("ref", boostRefSecond, r >> 4 & 1);
      chk("heavy_load_protect", heavyLoadOn, (i == 0) & (r >> 5));
      chk("lc", contrastOut, r >> 8 & 31);
      chk("lcact", contrastActive, i == 0);
    end
    $display("end power");
    for (d = 0; d < 2; d = d + 1)
      for (s = 0; s < 8; s = s + 1)
      begin
        bus(1, `SLD_OFS_CONTROL, 1 | d << 1);
        v = $urandom & 32'h700 | s & 3 | (s >> 2) << 4;
        bus(1, `SLD_OFS_DISPLAY, v);
        chk("drvsup", driveSupplyOn, !(d == 1 && (s & 3) == 0));
        chk("area", areaSel, v >> 8 & 1);
        chk("comord", comOrder, v >> 9 & 1);
        chk("segord", segOrder, v >> 10 & 1);
        chk("allon", waveAllOn, (s & 3) == 2);
        chk("alloff", waveAllOff, (s & 3) == 3);
        chk("static", commonStatic, (s & 3) == 3);
        chk("invert", waveInvert, s < 4 && (s & 3) != 3);
        chk("ground", pinsGrounded, d == 1 && (s & 3) == 0);
      end
    $display("end display");
    bus(1, `SLD_OFS_IRQ_FLAG, 1);
    bus(1, `SLD_OFS_IRQ_ENABLE, 1);
    i = 0;
    while (lcdTick !== 1'b1 && i < 9000)
    begin
      @(posedge mclk);
      i = i + 1;
    end
    chk("tick", lcdTick, 1);
    chk("irq", frameIrq, 1);
    bus(1, `SLD_OFS_CONTROL, 2);
    chk("clkoff", lcdClkEn, 0);
    bus(0, `SLD_OFS_IRQ_FLAG, 0);
    chk("flagheld", rd & 1, 1);
    bus(1, `SLD_OFS_IRQ_FLAG, 1);
    bus(0, `SLD_OFS_IRQ_FLAG, 0);
    chk("flagclr", rd & 1, 0);
    chk("irqclr", frameIrq, 0);
    $display("end irq");
    bus(1, `SLD_OFS_POWER, 1);
    extSupply <= 1'b0;
    bus(1, `SLD_OFS_POWER, 0);
    chk("ext0", extVoltageMask, 0);
    bus(1, `SLD_OFS_POWER, 1);
    chk("supply", supplyLive, 0);
    bus(1, `SLD_OFS_DISPLAY, 32'h10);
    chk("offgnd", pinsGrounded, 1);
    bus(0, `SLD_OFS_STATUS, 0);
    chk("status", rd, 32'h22);
    $display("end discharge");
    close_out;
  end
endmodule
bind sld_lcd_ctrl sld_lcd_ctrl_props sld_lcd_ctrl_props_i (.mclk(mclk), .resetn(resetn), .lcdClkEn(lcdClkEn),
  .lcdTick(lcdTick), .regulatorOn(regulatorOn), .boosterOn(boosterOn), .extVoltageMask(extVoltageMask),
  .contrastActive(contrastActive), .pinsGrounded(pinsGrounded), .waveAllOn(waveAllOn),
  .waveAllOff(waveAllOff), .commonStatic(commonStatic), .waveInvert(waveInvert), .dutyOut(dutyOut),
  .comActive(comActive), .sharedIsSeg(sharedIsSeg));
